// file: hw/clcu_ctrl.sv
// Controller side of a serial control link: sends command packets to a
// packet switch control unit and collects its replies.
// Assumes the far end keeps to the acknowledge and handshake protocol.
//
// What this block does
// - Byte after the header is the command code, parameters follow.
// - Body runs until an end-of-packet or end-of-message token.
// - Header then end-of-packet is an acknowledge; others are data.
// - No new data packet before the previous one is acknowledged.
// - Protocol-recover may be sent while an acknowledge is outstanding.
// - No new command before the previous one is handshaken.
// - Protocol-recover, Reset and Fault-acknowledge may be sent while a handshake waits.
// - Controller acknowledges every data packet it receives.
// - Command header labels are always two bytes.
// - Controller should send Start first to each device; the user must issue it, this block does not.
// - Reset may cut, fail or suppress a pending handshake; tolerate it.
`timescale 1ns/10ps

module clcu_fifo #(
   parameter int W = 9,
   parameter int D = 4
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0]   cnt_r;
   wire           push = in_valid & in_ready;
   wire           pop  = out_valid & out_ready;

   assign in_ready  = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wr_r <= (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
         if (pop)  rd_r <= (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // clcu_fifo

module clcu_ctrl (
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire clcu_pkg::clcu_cmd_t cmd,
   output logic                   rsp_valid,
   input  wire logic              rsp_ready,
   output clcu_pkg::clcu_tok_t    rsp,
   output logic                   ack_wait,
   output logic                   hs_wait,
   output logic                   rx_overrun,
   output logic                   lnk_tx_clk,
   output clcu_pkg::clcu_tok_t    lnk_tx_tok,
   input  wire logic              lnk_tx_credit,
   input  wire logic              lnk_rx_clk,
   input  wire clcu_pkg::clcu_tok_t lnk_rx_tok,
   output logic                   lnk_rx_credit
);
   localparam int SLOTS = clcu_pkg::TX_SLOTS;

   // Synchronisers for everything arriving from the link
   logic                rxc_s1_r, rxc_s2_r, rxc_s3_r;
   clcu_pkg::clcu_tok_t tok_s1_r, tok_s2_r;
   logic                crd_s1_r, crd_s2_r;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rxc_s1_r <= 1'b0;
         rxc_s2_r <= 1'b0;
         rxc_s3_r <= 1'b0;
         tok_s1_r <= '0;
         tok_s2_r <= '0;
         crd_s1_r <= 1'b0;
         crd_s2_r <= 1'b0;
      end else begin
         rxc_s1_r <= lnk_rx_clk;
         rxc_s2_r <= rxc_s1_r;
         rxc_s3_r <= rxc_s2_r;
         tok_s1_r <= lnk_rx_tok;
         tok_s2_r <= tok_s1_r;
         crd_s1_r <= lnk_tx_credit;
         crd_s2_r <= crd_s1_r;
      end
   end

   // Receive parsing
   logic [1:0]  rx_pos_r;
   logic [7:0]  hs_code_r;
   logic [15:0] label_r;
   logic        ack_owed_r, ack_wait_r, hs_wait_r, overrun_r;
   logic        fifo_in_ready;

   wire rx_stb   = rxc_s2_r & ~rxc_s3_r;
   wire rx_ctrl  = tok_s2_r.ctrl;
   wire rx_body  = rx_stb & (rx_pos_r >= 2'd2);
   wire rx_first = rx_stb & (rx_pos_r == 2'd2);
   wire is_ack   = rx_first & rx_ctrl
                   & (tok_s2_r.data == clcu_pkg::TOK_EOP);
   wire rx_push  = rx_body & ~is_ack;
   wire data_end = rx_push & rx_ctrl;
   wire hs_hit   = rx_first & ~rx_ctrl & hs_wait_r
                   & (tok_s2_r.data == hs_code_r);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_pos_r <= 2'd0;
      end else if (rx_stb) begin
         if (rx_ctrl) rx_pos_r <= 2'd0;
         else if (rx_pos_r != 2'd3) rx_pos_r <= rx_pos_r + 2'd1;
      end
   end

   // Replies go to the user through the buffer; the credit throttles the
   // device, but sync latency means a fast device may still overrun it.
   clcu_fifo #(.W(clcu_pkg::TOK_W), .D(clcu_pkg::FIFO_DEPTH)) u_rx_fifo (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_valid  (rx_push),
      .in_ready  (fifo_in_ready),
      .in_data   (tok_s2_r),
      .out_valid (rsp_valid),
      .out_ready (rsp_ready),
      .out_data  (rsp)
   );
   assign lnk_rx_credit = fifo_in_ready;

   // Transmit side
   clcu_pkg::clcu_tok_t tx_buf_r [SLOTS];
   clcu_pkg::clcu_tok_t fill [SLOTS];
   logic [3:0]          tx_len_r, tx_idx_r, div_r;
   logic                tx_busy_r, clk_hi_r;
   clcu_pkg::clcu_tok_t tx_tok_r;

   wire is_recover = (cmd.code == clcu_pkg::CMD_RECOVER);
   wire is_reset   = (cmd.code == clcu_pkg::CMD_RESET);
   wire is_hs_pkt  = (cmd.code == clcu_pkg::CMD_FAULT_ACK);
   wire ack_ok     = ~ack_wait_r | is_recover;
   wire hs_ok      = ~hs_wait_r | is_recover | is_reset | is_hs_pkt;
   wire tx_free    = ~tx_busy_r & ~ack_owed_r;
   wire load_ack   = ~tx_busy_r & ack_owed_r;
   wire load_cmd   = tx_free & cmd_valid & ack_ok & hs_ok;
   wire div_zero   = (div_r == 4'd0);
   wire tx_go      = tx_busy_r & div_zero & crd_s2_r;

   assign cmd_ready = tx_free & ack_ok & hs_ok;

   // Header low byte first, code, parameters low first, end-of-message
   always_comb begin
      for (int i = 0; i < SLOTS; i++) begin
         fill[i] = '0;
      end
      fill[0] = '{1'b0, load_ack ? label_r[7:0] : cmd.label[7:0]};
      fill[1] = '{1'b0, load_ack ? label_r[15:8] : cmd.label[15:8]};
      if (load_ack) begin
         fill[2] = '{1'b1, clcu_pkg::TOK_EOP};
      end else begin
         fill[2] = '{1'b0, cmd.code};
         for (int k = 0; k < clcu_pkg::MAX_PARM; k++) begin
            if (3'(k) < cmd.nparm) begin
               fill[3+k] = '{1'b0, cmd.parm[8*k +: 8]};
            end else if (3'(k) == cmd.nparm) begin
               fill[3+k] = '{1'b1, clcu_pkg::TOK_EOM};
            end
         end
         if (cmd.nparm >= 3'(clcu_pkg::MAX_PARM)) begin
            fill[SLOTS-1] = '{1'b1, clcu_pkg::TOK_EOM};
         end
      end
   end

   wire [2:0] nparm_c = (cmd.nparm > 3'(clcu_pkg::MAX_PARM))
                        ? 3'(clcu_pkg::MAX_PARM) : cmd.nparm;

   always_ff @(posedge sys_clk) begin
      if (load_ack | load_cmd) begin
         for (int i = 0; i < SLOTS; i++) begin
            tx_buf_r[i] <= fill[i];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_busy_r <= 1'b0;
         tx_len_r  <= 4'd0;
         tx_idx_r  <= 4'd0;
      end else if (load_ack) begin
         tx_busy_r <= 1'b1;
         tx_len_r  <= 4'd3;
         tx_idx_r  <= 4'd0;
      end else if (load_cmd) begin
         tx_busy_r <= 1'b1;
         tx_len_r  <= 4'd4 + 4'(nparm_c);
         tx_idx_r  <= 4'd0;
      end else if (tx_go) begin
         tx_idx_r <= tx_idx_r + 4'd1;
         if (tx_idx_r == tx_len_r - 4'd1) tx_busy_r <= 1'b0;
      end
   end

   // Link clock made by dividing the system clock; it idles low
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         div_r    <= 4'd0;
         clk_hi_r <= 1'b0;
         tx_tok_r <= '0;
      end else begin
         div_r <= (div_r == 4'(clcu_pkg::LINK_DIV - 1)) ? 4'd0 : div_r + 4'd1;
         if (tx_go) begin
            clk_hi_r <= 1'b1;
            tx_tok_r <= tx_buf_r[tx_idx_r];
         end else if (div_r == 4'(clcu_pkg::LINK_HALF)) begin
            clk_hi_r <= 1'b0;
         end
      end
   end
   assign lnk_tx_clk = clk_hi_r;
   assign lnk_tx_tok = tx_tok_r;

   // Protocol state; a hardware set wins over a same-cycle clear
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ack_owed_r <= 1'b0;
         ack_wait_r <= 1'b0;
         hs_wait_r  <= 1'b0;
         overrun_r  <= 1'b0;
         hs_code_r  <= 8'h00;
         label_r    <= 16'h0000;
      end else begin
         ack_owed_r <= data_end | (ack_owed_r & ~load_ack);
         ack_wait_r <= load_cmd | (ack_wait_r & ~is_ack);
         overrun_r  <= overrun_r | (rx_push & ~fifo_in_ready);
         if (load_cmd) begin
            label_r <= cmd.label;
         end
         // A Reset re-arms the wait, so a lost earlier handshake is moot
         if (load_cmd & ~is_hs_pkt) begin
            hs_wait_r <= 1'b1;
            hs_code_r <= cmd.code ^ clcu_pkg::HS_FLIP;
         end else if (hs_hit) begin
            hs_wait_r <= 1'b0;
         end
      end
   end
   assign ack_wait   = ack_wait_r;
   assign hs_wait    = hs_wait_r;
   assign rx_overrun = overrun_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   chk_data_ack_gate: assert property (
      load_cmd && cmd.code != clcu_pkg::CMD_RECOVER |-> !ack_wait_r)
      else $error("data packet sent before acknowledge");
   chk_cmd_hs_gate: assert property (
      load_cmd && !is_recover && !is_reset && !is_hs_pkt |-> !hs_wait_r)
      else $error("command sent before handshake");
   chk_ack_owed_set: assert property (
      data_end |=> ack_owed_r || tx_busy_r)
      else $error("received data packet left unacknowledged");
   chk_ack_shape: assert property (
      load_ack |=> tx_len_r == 4'd3 && tx_buf_r[2].ctrl
      && tx_buf_r[2].data == clcu_pkg::TOK_EOP)
      else $error("acknowledge packet malformed");
   chk_start_order: assert property (
      load_cmd && cmd.code == clcu_pkg::CMD_START && cmd.nparm == 3'd2
      |=> tx_buf_r[3].data == $past(cmd.parm[7:0])
      && tx_buf_r[4].data == $past(cmd.parm[15:8]))
      else $error("start return header out of order");
   chk_cmd_term: assert property (
      load_cmd |=> tx_buf_r[tx_len_r - 4'd1].ctrl
      && tx_buf_r[tx_len_r - 4'd1].data == clcu_pkg::TOK_EOM)
      else $error("command not closed by end-of-message");
   chk_hs_release: assert property (
      hs_hit && !load_cmd |=> !hs_wait_r)
      else $error("matching handshake did not release");
   chk_tx_credit: assert property (
      $rose(clk_hi_r) |-> $past(crd_s2_r))
      else $error("token sent without flow credit");
   chk_clk_high: assert property (
      tx_go |=> clk_hi_r [*6] ##1 !clk_hi_r)
      else $error("link clock high phase wrong");
   chk_label_hdr: assert property (
      load_cmd |=> tx_buf_r[0].data == $past(cmd.label[7:0])
      && tx_buf_r[1].data == $past(cmd.label[15:8]))
      else $error("header label not sent low byte first");
endmodule // clcu_ctrl

// file: hw/clcu_pkg.sv
// Shared constants and carriers for the control-link command unit driver.
// Assumes a 250 MHz system clock and a token link of byte and
// terminator tokens, nine bits each.
package clcu_pkg;
   // Token layout: bit 8 set marks a terminator, bits 7:0 carry data
   localparam int        TOK_W        = 9;
   localparam int        TOK_CTRL_BIT = 8;
   localparam logic [7:0] TOK_EOP     = 8'h00;
   localparam logic [7:0] TOK_EOM     = 8'h01;

   // Timing
   localparam int CLK_PERIOD_NS  = 4;
   localparam int LINK_PERIOD_NS = 48;
   localparam int LINK_DIV       = LINK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int LINK_HALF      = LINK_DIV / 2;

   // Command codes; values are plain defaults, not taken from any part
   localparam logic [7:0] CMD_START     = 8'h00;
   localparam logic [7:0] CMD_RESET     = 8'h01;
   localparam logic [7:0] CMD_IDENTIFY  = 8'h02;
   localparam logic [7:0] CMD_PEEK      = 8'h03;
   localparam logic [7:0] CMD_POKE      = 8'h04;
   localparam logic [7:0] CMD_RECOVER   = 8'h05;
   localparam logic [7:0] CMD_FAULT_ACK = 8'h06;
   localparam logic [7:0] HS_FLIP       = 8'h80;

   // Packet geometry
   localparam int HDR_BYTES = 2;
   localparam int MAX_PARM  = 6;
   localparam int TX_SLOTS  = HDR_BYTES + 1 + MAX_PARM + 1;
   localparam int FIFO_DEPTH = 4;

   typedef struct packed {
      logic [15:0] label;
      logic [7:0]  code;
      logic [2:0]  nparm;
      logic [47:0] parm;
   } clcu_cmd_t;

   typedef struct packed {
      logic       ctrl;
      logic [7:0] data;
   } clcu_tok_t;
endpackage

// file: tb/clcu_ctrl_tb.sv
// Self-checking bench for the control-link command unit driver.
// Assumes clcu_dev_model answers on the far side of the link.
`timescale 1ns/10ps
module clcu_ctrl_tb;
   localparam logic [15:0] TID = 16'h5a3c; // Arbitrary type value
   localparam logic [15:0] LBL = 16'h1234;
   logic                sys_clk, sys_rst, cmd_valid, rsp_ready, stall;
   logic                cmd_ready, rsp_valid, ack_wait, hs_wait;
   logic                rx_overrun, lnk_tx_clk, lnk_tx_credit;
   logic                lnk_rx_clk, lnk_rx_credit;
   clcu_pkg::clcu_cmd_t cmd;
   clcu_pkg::clcu_tok_t rsp, lnk_tx_tok, lnk_rx_tok;
   int                  n_fail, check_count, i;

   clcu_ctrl clcu_ctrl_i (.sys_clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd,
      .rsp_valid, .rsp_ready, .rsp, .ack_wait, .hs_wait, .rx_overrun,
      .lnk_tx_clk, .lnk_tx_tok, .lnk_tx_credit, .lnk_rx_clk, .lnk_rx_tok,
      .lnk_rx_credit);
   clcu_dev_model #(.TYPE_ID(TID)) clcu_dev_model_i (.lnk_tx_clk,
      .lnk_tx_tok, .lnk_tx_credit, .lnk_rx_clk, .lnk_rx_tok,
      .lnk_rx_credit, .stall);

   always #2 sys_clk = ~sys_clk;

   task bad(input string m);
      n_fail++;
      $display("BAD %0t %s", $time, m);
   endtask
   task cmp1(input logic g, input logic e, input string m);
      check_count++;
      if (g !== e) bad(m);
   endtask
   task cmp9(input logic [8:0] g, input logic [8:0] e, input string m);
      check_count++;
      if (g !== e) bad(m);
   endtask
   task cmp16(input logic [15:0] g, input logic [15:0] e, input string m);
      check_count++;
      if (g !== e) bad(m);
   endtask

   task send(input logic [7:0] c, input logic [2:0] n, input logic [47:0] p);
      cmd.code = c;
      cmd.nparm = n;
      cmd.parm = p;
      cmd_valid = 1'b1;
      for (i = 0; cmd_ready !== 1'b1 && i < 5000; i++) @(negedge sys_clk);
      if (i >= 5000) bad("command never taken");
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      cmp1(ack_wait, 1'b1, "ack_wait not set");
      cmp1(hs_wait, 1'b1, "hs_wait not set");
   endtask

   task pop(input logic [8:0] e);
      for (i = 0; rsp_valid !== 1'b1 && i < 3000; i++) @(negedge sys_clk);
      if (i >= 3000) bad("reply timeout");
      cmp9(rsp, e, "reply token");
      rsp_ready = 1'b1;
      @(negedge sys_clk);
      rsp_ready = 1'b0;
      // Let an edge pass so a following pop never re-raises in one step
      @(negedge sys_clk);
   endtask

   task hs(input logic [7:0] c);
      pop({1'b0, c ^ 8'h80});
      pop(9'h000);
      pop(9'h101);
   endtask

   task settle(input int n);
      for (i = 0; i < 5000 && (clcu_dev_model_i.n_ack != n ||
           hs_wait !== 1'b0 || ack_wait !== 1'b0); i++) @(negedge sys_clk);
      cmp1(clcu_dev_model_i.n_ack == n, 1'b1, "acks to device");
      cmp1(hs_wait, 1'b0, "hs_wait stuck");
   endtask

   task t_start;
      send(clcu_pkg::CMD_START, 3'd2, 48'habcd);
      hs(clcu_pkg::CMD_START);
      settle(1);
      cmp16(clcu_dev_model_i.label, LBL, "label");
      cmp16(clcu_dev_model_i.ack_hdr, 16'h0000, "ack header");
      cmp16(clcu_dev_model_i.hs_hdr, 16'habcd, "new header");
      $display("t_start done");
   endtask

   task t_fifo;
      send(clcu_pkg::CMD_IDENTIFY, 3'd0, 48'h0);
      for (i = 0; lnk_rx_credit !== 1'b0 && i < 3000; i++)
         @(negedge sys_clk);
      repeat (60) @(negedge sys_clk);
      cmp1(lnk_rx_credit, 1'b0, "credit while full");
      cmp1(rx_overrun, 1'b0, "overrun");
      pop(9'h082);
      pop({1'b0, TID[7:0]});
      pop({1'b0, TID[15:8]});
      pop(9'h000);
      pop(9'h000);
      pop(9'h101);
      settle(2);
      $display("t_fifo done");
   endtask

   task t_stall;
      int hi;
      hi = 0;
      stall = 1'b1;
      repeat (4) @(negedge sys_clk);
      send(clcu_pkg::CMD_RESET, 3'd1, 48'h1);
      repeat (60) begin
         @(negedge sys_clk);
         if (lnk_tx_clk !== 1'b0) hi++;
      end
      cmp1(hi == 0, 1'b1, "sent while stalled");
      stall = 1'b0;
      hs(clcu_pkg::CMD_RESET);
      settle(3);
      $display("t_stall done");
   endtask

   task t_unknown;
      send(8'h07, 3'd0, 48'h0);
      pop(9'h0c0);
      pop(9'h000);
      pop(9'h101);
      for (i = 0; clcu_dev_model_i.n_ack != 4 && i < 3000; i++)
         @(negedge sys_clk);
      cmd.code = clcu_pkg::CMD_IDENTIFY;
      #1;
      cmp1(cmd_ready, 1'b0, "command while handshake owed");
      send(clcu_pkg::CMD_RECOVER, 3'd0, 48'h0);
      hs(clcu_pkg::CMD_RECOVER);
      settle(5);
      $display("t_unknown done");
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      sys_rst = 1'b1;
      cmd_valid = 1'b0;
      rsp_ready = 1'b0;
      stall = 1'b0;
      cmd = '0;
      cmd.label = LBL;
      n_fail = 0;
      check_count = 0;
      repeat (4) @(negedge sys_clk);
      sys_rst = 1'b0;
      cmp1(cmd_ready, 1'b1, "ready after reset");
      cmp1(lnk_rx_credit, 1'b1, "credit after reset");
      t_start;
      t_fifo;
      t_stall;
      t_unknown;
      wrap_up;
   end

   // Whole run needs just over a thousand cycles; this cuts a hang short
   initial begin
      #80000;
      n_fail++;
      wrap_up;
   end
endmodule // clcu_ctrl_tb

// file: tb/clcu_dev_model.sv
// Behavioural model of the switch control unit on the far link end.
// Assumes the controller sends whole packets, header low byte first.
`timescale 1ns/10ps
module clcu_dev_model #(
   parameter logic [15:0] TYPE_ID = 16'h5a3c // Arbitrary type value
) (
   input  wire logic                lnk_tx_clk,
   input  wire clcu_pkg::clcu_tok_t lnk_tx_tok,
   output logic                     lnk_tx_credit,
   output logic                     lnk_rx_clk,
   output clcu_pkg::clcu_tok_t      lnk_rx_tok,
   input  wire logic                lnk_rx_credit,
   input  wire logic                stall
);
   logic [8:0]  q[$];
   logic [8:0]  p[$];
   logic [8:0]  b[$];
   logic [8:0]  t;
   logic [7:0]  c;
   logic [15:0] label, ret_hdr, ack_hdr, hs_hdr;
   logic        have_label, started;
   int          n_ack;

   assign lnk_tx_credit = !stall;

   // Sample late so the token register has settled behind the clock
   always begin
      @(posedge lnk_tx_clk);
      #2;
      q.push_back(lnk_tx_tok);
   end

   task put(input logic [8:0] v);
      while (lnk_rx_credit !== 1'b1) #4;
      lnk_rx_tok = v;
      #24 lnk_rx_clk = 1'b1;
      #24 lnk_rx_clk = 1'b0;
   endtask

   task frame(input logic [15:0] h);
      put({1'b0, h[7:0]});
      put({1'b0, h[15:8]});
      foreach (b[i]) put(b[i]);
      // Released data line must not look like a held token
      lnk_rx_tok = ~lnk_rx_tok;
   endtask

   initial begin
      lnk_rx_clk = 1'b0;
      lnk_rx_tok = '0;
      have_label = 1'b0;
      started = 1'b0;
      ret_hdr = 16'h0000;
      n_ack = 0;
      forever begin
         while (q.size() == 0) #1;
         t = q.pop_front();
         p.push_back(t);
         if (t[8]) begin
            if (p.size() == 3 && t == 9'h100) begin
               n_ack++;
            end else begin
               if (!have_label) begin
                  label = {p[1][7:0], p[0][7:0]};
                  have_label = 1'b1;
               end
               c = p[2][7:0];
               // No chain port here: a foreign header gets a reply coded 0c1
               if (label != {p[1][7:0], p[0][7:0]}) begin
                  b = '{9'h0c1, 9'h000, 9'h101};
                  frame(ret_hdr);
               end else begin
                  b = '{9'h100};
                  ack_hdr = ret_hdr;
                  frame(ret_hdr);
                  b = '{{1'b0, c ^ 8'h80}, 9'h000};
                  if (c == clcu_pkg::CMD_START) begin
                     ret_hdr = {p[4][7:0], p[3][7:0]};
                     started = 1'b1;
                  end
                  if (c == clcu_pkg::CMD_IDENTIFY) begin
                     b = '{{1'b0, c ^ 8'h80}, {1'b0, TYPE_ID[7:0]},
                           {1'b0, TYPE_ID[15:8]}, 9'h000, 9'h000};
                  end
                  if (c == clcu_pkg::CMD_PEEK) begin
                     b = '{{1'b0, c ^ 8'h80}, 9'h001};
                  end
                  if (c > clcu_pkg::CMD_FAULT_ACK) begin
                     if (!started) begin
                        b = '{{1'b0, clcu_pkg::CMD_START ^ 8'h80},
                              9'h000, 9'h101};
                        frame(ret_hdr);
                     end
                     b = '{9'h0c0, 9'h000};
                  end
                  b.push_back(9'h101);
                  hs_hdr = ret_hdr;
                  frame(ret_hdr);
               end
            end
            p.delete();
         end
      end
   end
endmodule // clcu_dev_model
